// *** core/usb_sof_defs.svh ***
`ifndef USB_SOF_DEFS_SVH
`define USB_SOF_DEFS_SVH
// byte addresses on the wishbone slave
`define ADDR_CONTROL_REGISTER   12'h094
`define ADDR_TRANSCEIVER_CTRL   12'h10C
`define ADDR_FRAME_LENGTH_TRIM  12'h114
`define ADDR_FRAME_STATUS       12'h118
// control_register fields
`define CTL_HOST_MODE_EN_BIT    3
`define CTL_USB_EN_BIT          0
// transceiver_control_status fields
`define TRC_ASYNC_RESUME_EN_BIT 5
`define TRC_SYNC_IRQ_DETECTED_BIT        1
`define TRC_RESUME_INT_BIT      0
`define TRC_FIXED_ONE_BIT       6
// reset values
`define CONTROL_RESET           8'h00
`define TRC_RESET               8'h00
`define TRIM_RESET              8'h00
// frame timing
`define USB_CLK_HZ              12000000
`define FRAME_NOMINAL_CYCLES    12000
`define FRAME_US                1000
`define SYS_CLK_HZ              50000000
// 12 MHz tick from the 50 MHz clock: phase accumulator step over modulus
`define TICK_STEP               16'h0006
`define TICK_MOD                16'h0019
`define TICK_WIDTH              16
`endif

// *** core/usb_sof_pkg.sv ***
package usb_sof_pkg;
  typedef enum logic [2:0] {
    ST_PERIPH = 3'b001,
    ST_HOST   = 3'b010,
    ST_SOF    = 3'b100
  } role_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic dp_raw;
    logic dm_raw;
    logic sync_resume;
  } line_in_t;
endpackage

// *** core/usb_frame_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_frame_counter (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [7:0]  trim,
  output logic             sof,
  output logic [13:0]      count
);
  `include "usb_sof_defs.svh"
  typedef struct packed {
    logic [13:0] cnt;
    logic [13:0] len;
    logic        sof;
  } fc_state_t;
  fc_state_t s_reg;
  fc_state_t s_next;
  logic [13:0] next_len;

  always_comb begin
    // two's complement trim added to nominal length
    next_len = 14'(`FRAME_NOMINAL_CYCLES) + {{6{trim[7]}}, trim}; // see [R7] see [R8]
    s_next = s_reg;
    s_next.sof = 1'b0;
    if (!run) begin
      s_next.cnt = 14'h0000;
      s_next.len = next_len;
    end else if (tick) begin
      if (s_reg.cnt == s_reg.len - 14'h0001) begin
        s_next.cnt = 14'h0000;
        s_next.sof = 1'b1; // see [R6]
        // while running, length latched only at frame boundary; while stopped it follows trim every cycle
        s_next.len = next_len; // see [R9]
      end else begin
        s_next.cnt = s_reg.cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '{cnt: 14'h0000, len: 14'(`FRAME_NOMINAL_CYCLES), sof: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sof   = s_reg.sof;
  assign count = s_reg.cnt;
endmodule
`default_nettype wire

// *** core/usb_sof_resume.sv ***
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] async resume enable 1 allows async wakeup; 0 blocks it
// [R2] async detector sees K-state on raw D+/D- without clocked filtering
// [R3] software should set async enable only while transceiver suspended
// [R4] sync detect flag reads 1 after synchronous resume interrupt seen
// [R5] async interrupt flag reads 1 after async detector raised interrupt
// [R6] host mode emits SOF every 12000 cycles of 12 MHz
// [R7] trim field is two's complement added to frame period
// [R8] trim covers -128 to +127 clock periods
// [R9] new trim takes effect from the next frame
// [R10] host mode active when control host enable bit set
// [R11] controller is peripheral or host, never both
// [R12] host mode uses endpoint zero only
// [R13] host mode supports bulk, iso, interrupt and control transfers
// [R14] async wakeup event to processor only in device mode
// [R15] flags and trim reset to zero, frames start nominal
module usb_sof_resume (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire usb_sof_pkg::wb_req_t wb_req,
  output usb_sof_pkg::wb_rsp_t     wb_rsp,
  input  wire usb_sof_pkg::line_in_t line_in,
  input  wire logic                suspended,
  output logic                     host_mode,
  output logic                     periph_mode,
  output logic                     ep_nonzero_en,
  output logic                     sof_pulse,
  output logic                     wakeup
);
  import usb_sof_pkg::*;
  `include "usb_sof_defs.svh"

  typedef struct packed {
    wb_rsp_t     rsp;
    logic [7:0]  ctl;
    logic        async_en;
    logic        sync_irq_detected;
    logic        resume_int;
    logic [7:0]  trim;
    role_state_t role;
    logic [`TICK_WIDTH-1:0] phase;
    logic        tick;
    logic        sof;
    logic        wake;
    logic        ep_en;
    logic        host;
    logic        periph;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;
  logic        fc_sof;
  logic [13:0] fc_count;
  logic        k_state;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [`TICK_WIDTH-1:0] phase_sum;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a[11:2] == r[11:2]);
  endfunction

  // full-speed K: D+ low, D- high, sampled unfiltered
  assign k_state = !line_in.dp_raw && line_in.dm_raw; // see [R2]
  assign wr = wb_req.cyc && wb_req.stb && wb_req.we && !s_reg.rsp.ack;
  assign rd = wb_req.cyc && wb_req.stb && !wb_req.we && !s_reg.rsp.ack;
  assign phase_sum = s_reg.phase + `TICK_STEP;

  usb_frame_counter usb_frame_counter_inst (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .run     (s_reg.role != ST_PERIPH),
    .tick    (s_reg.tick),
    .trim    (s_reg.trim),
    .sof     (fc_sof),
    .count   (fc_count)
  );

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit(wb_req.adr, `ADDR_CONTROL_REGISTER)) begin
      rdata[7:0] = s_reg.ctl;
    end else if (hit(wb_req.adr, `ADDR_TRANSCEIVER_CTRL)) begin
      rdata[`TRC_ASYNC_RESUME_EN_BIT] = s_reg.async_en;
      rdata[`TRC_SYNC_IRQ_DETECTED_BIT]        = s_reg.sync_irq_detected; // see [R4]
      rdata[`TRC_RESUME_INT_BIT]      = s_reg.resume_int; // see [R5]
    end else if (hit(wb_req.adr, `ADDR_FRAME_LENGTH_TRIM)) begin
      rdata[7:0] = s_reg.trim;
    end else if (hit(wb_req.adr, `ADDR_FRAME_STATUS)) begin
      rdata[13:0] = fc_count;
      rdata[16]   = s_reg.role != ST_PERIPH;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.rsp.ack = wb_req.cyc && wb_req.stb && !s_reg.rsp.ack;
    s_next.rsp.dat = rd ? rdata : 32'h0000_0000;
    s_next.sof  = 1'b0;
    s_next.wake = 1'b0;
    // fractional divider: 6/25 of 50 MHz = 12 MHz tick
    if (phase_sum >= `TICK_MOD) begin
      s_next.phase = phase_sum - `TICK_MOD;
      s_next.tick  = 1'b1;
    end else begin
      s_next.phase = phase_sum;
      s_next.tick  = 1'b0;
    end
    if (wr && wb_req.sel[0]) begin
      if (hit(wb_req.adr, `ADDR_CONTROL_REGISTER)) begin
        s_next.ctl = wb_req.dat[7:0];
      end else if (hit(wb_req.adr, `ADDR_TRANSCEIVER_CTRL)) begin
        s_next.async_en = wb_req.dat[`TRC_ASYNC_RESUME_EN_BIT]; // see [R1]
        // write one clears the sticky flags
        if (wb_req.dat[`TRC_SYNC_IRQ_DETECTED_BIT]) begin
          s_next.sync_irq_detected = 1'b0;
        end
        if (wb_req.dat[`TRC_RESUME_INT_BIT]) begin
          s_next.resume_int = 1'b0;
        end
      end else if (hit(wb_req.adr, `ADDR_FRAME_LENGTH_TRIM)) begin
        s_next.trim = wb_req.dat[7:0]; // see [R7]
      end
    end
    // detection set after clear so a same-cycle event wins
    if (line_in.sync_resume) begin
      s_next.sync_irq_detected = 1'b1; // see [R4]
    end
    // wakeup only as peripheral; a pending host enable already counts as host
    if (s_reg.async_en && k_state && s_reg.role == ST_PERIPH &&
        !s_reg.ctl[`CTL_HOST_MODE_EN_BIT]) begin // see [R1] see [R14]
      s_next.resume_int = 1'b1; // see [R5]
      s_next.wake       = 1'b1; // see [R14]
    end
    // single role state: one-hot guarantees exclusive modes
    case (s_reg.role)
      ST_PERIPH: begin
        if (s_reg.ctl[`CTL_HOST_MODE_EN_BIT]) begin
          s_next.role = ST_HOST; // see [R10] see [R11]
        end
      end
      ST_HOST: begin
        if (!s_reg.ctl[`CTL_HOST_MODE_EN_BIT]) begin
          s_next.role = ST_PERIPH; // see [R11]
        end else if (fc_sof) begin
          s_next.role = ST_SOF;
        end
      end
      ST_SOF: begin
        s_next.role = s_reg.ctl[`CTL_HOST_MODE_EN_BIT] ? ST_HOST : ST_PERIPH;
      end
      default: begin
        s_next.role = ST_PERIPH;
      end
    endcase
    // usb enable gates the SOF packet, the timer keeps running
    // next role, so no pulse escapes in the cycle host mode ends
    s_next.sof = fc_sof && s_reg.ctl[`CTL_USB_EN_BIT] && s_next.role != ST_PERIPH; // see [R6]
    s_next.host   = s_next.role != ST_PERIPH; // see [R10] see [R11]
    s_next.periph = s_next.role == ST_PERIPH; // see [R11]
    // host mode: only endpoint zero; all transfer types stay on ep0
    s_next.ep_en = (s_next.role == ST_PERIPH); // see [R12] see [R13]
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg.rsp        <= '0;
      s_reg.ctl        <= `CONTROL_RESET;
      s_reg.async_en   <= 1'b0;
      s_reg.sync_irq_detected   <= 1'b0; // see [R15]
      s_reg.resume_int <= 1'b0; // see [R15]
      s_reg.trim       <= `TRIM_RESET; // see [R15]
      s_reg.role       <= ST_PERIPH;
      s_reg.phase      <= '0;
      s_reg.tick       <= 1'b0;
      s_reg.sof        <= 1'b0;
      s_reg.wake       <= 1'b0;
      s_reg.ep_en      <= 1'b1;
      s_reg.host       <= 1'b0;
      s_reg.periph     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_rsp        = s_reg.rsp;
  assign host_mode     = s_reg.host;
  assign periph_mode   = s_reg.periph;
  assign ep_nonzero_en = s_reg.ep_en;
  assign sof_pulse     = s_reg.sof;
  assign wakeup        = s_reg.wake;
endmodule
`default_nettype wire

// *** dv/usb_sof_resume_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_sof_resume_checker (
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire usb_sof_pkg::wb_req_t wb_req,
  input wire usb_sof_pkg::wb_rsp_t wb_rsp,
  input wire usb_sof_pkg::line_in_t line_in,
  input wire logic                 host_mode,
  input wire logic                 periph_mode,
  input wire logic                 ep_nonzero_en,
  input wire logic                 sof_pulse,
  input wire logic                 wakeup
);
  import usb_sof_pkg::*;
  logic [16:0] gap;
  logic        seen;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // gap only trusted between two pulses inside one host session
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gap <= '0;
      seen <= 1'b0;
    end else begin
      gap <= sof_pulse ? '0 : gap + 17'h1;
      seen <= host_mode && (seen || sof_pulse);
    end
  end
  one_role_a: assert property (host_mode != periph_mode)
    else $error("roles not exclusive");
  host_ep0_a: assert property (host_mode |-> !ep_nonzero_en)
    else $error("endpoints open in host mode");
  ack_next_a: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("ack late");
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack too long");
  sof_host_a: assert property (sof_pulse |-> host_mode)
    else $error("sof outside host mode");
  sof_gap_a: assert property (sof_pulse && seen |-> gap > 17'h0C094 && gap < 17'h0C5A8)
    else $error("frame length out of range");
  wake_dev_a: assert property (wakeup |-> periph_mode)
    else $error("wakeup in host mode");
  wake_k_a: assert property (!line_in.dm_raw [*4] |=> !wakeup)
    else $error("wakeup without k state");
  cover property (sof_pulse && seen);
  cover property (wakeup);
  cover property ($rose(host_mode));
endmodule
`default_nettype wire

// *** dv/usb_line_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_line_partner (
  input  wire logic              clk_sys,
  input  wire logic              resume_req,
  input  wire logic              sync_req,
  output usb_sof_pkg::line_in_t  line
);
  import usb_sof_pkg::*;
  // idle is j from the pull-up; k drives dp low and dm high
  initial line = '{1'b1, 1'b0, 1'b0};
  always @(posedge clk_sys) begin
    line <= '{!resume_req, resume_req, sync_req};
  end
endmodule
`default_nettype wire

// *** dv/tb_usb_sof_resume.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "usb_sof_defs.svh"
module tb_usb_sof_resume;
  import usb_sof_pkg::*;
  logic        clk_sys = 0;
  logic        nrst = 0;
  logic        suspended = 0;
  logic        k_req = 0;
  logic        sync_req = 0;
  wb_req_t     wb_req = '0;
  wb_rsp_t     wb_rsp;
  line_in_t    line_in;
  logic        host_mode, periph_mode, ep_nonzero_en, sof_pulse, wakeup;
  logic [31:0] rd;
  int          err_count = 0;
  int          cmp_count = 0;
  int          n, t0, cyc = 0, wake_n = 0, w0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (wakeup === 1'b1) wake_n <= wake_n + 1;
  end
  usb_line_partner usb_line_partner_inst (.clk_sys(clk_sys), .resume_req(k_req),
    .sync_req(sync_req), .line(line_in));
  usb_sof_resume usb_sof_resume_inst (.clk_sys(clk_sys), .nrst(nrst), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .line_in(line_in), .suspended(suspended), .host_mode(host_mode),
    .periph_mode(periph_mode), .ep_nonzero_en(ep_nonzero_en), .sof_pulse(sof_pulse),
    .wakeup(wakeup));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int lim);
    if (n >= lim) begin
      err_count++;
      $display("mismatch at %0t: wait timed out", $time);
      end_of_test();
    end
  endtask
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] d);
    wb_req <= '{1'b1, 1'b1, we, 4'hF, adr, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    tmo(20);
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask
  task automatic kpulse();
    w0 = wake_n;
    k_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    k_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic wait_sof();
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sof_pulse !== 1'b1 && n < 60000);
    tmo(60000);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk(32'({host_mode, periph_mode, ep_nonzero_en}), 32'h3);
    rdchk(`ADDR_TRANSCEIVER_CTRL, 32'h0);
    rdchk(`ADDR_FRAME_LENGTH_TRIM, 32'h0);
    rdchk(12'h200, 32'h0);
    kpulse();
    chk(32'(wake_n - w0), 32'h0);
    rdchk(`ADDR_TRANSCEIVER_CTRL, 32'h0);
    suspended <= 1'b1;
    bus(1'b1, `ADDR_TRANSCEIVER_CTRL, 32'h20);
    kpulse();
    chk(32'(wake_n > w0), 32'h1);
    rdchk(`ADDR_TRANSCEIVER_CTRL, 32'h21);
    bus(1'b1, `ADDR_TRANSCEIVER_CTRL, 32'h21);
    sync_req <= 1'b1;
    @(posedge clk_sys);
    sync_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdchk(`ADDR_TRANSCEIVER_CTRL, 32'h22);
    bus(1'b1, `ADDR_FRAME_LENGTH_TRIM, 32'h80);
    rdchk(`ADDR_FRAME_LENGTH_TRIM, 32'h80);
    bus(1'b1, `ADDR_CONTROL_REGISTER, 32'h09);
    rdchk(`ADDR_CONTROL_REGISTER, 32'h09);
    chk(32'({host_mode, periph_mode, ep_nonzero_en}), 32'h4);
    wait_sof();
    t0 = cyc;
    // a new trim mid-frame must leave this frame at -128
    bus(1'b1, `ADDR_FRAME_LENGTH_TRIM, 32'h7F);
    wait_sof();
    chk(32'(cyc - t0 > 49464 && cyc - t0 < 49469), 32'h1);
    kpulse();
    chk(32'(wake_n - w0), 32'h0);
    bus(1'b1, `ADDR_CONTROL_REGISTER, 32'h00);
    chk(32'({host_mode, periph_mode, ep_nonzero_en}), 32'h3);
    rdchk(`ADDR_FRAME_STATUS, 32'h0);
    end_of_test();
  end
endmodule
bind usb_sof_resume usb_sof_resume_checker usb_sof_resume_checker_inst (.clk_sys(clk_sys),
  .nrst(nrst), .wb_req(wb_req), .wb_rsp(wb_rsp), .line_in(line_in), .host_mode(host_mode),
  .periph_mode(periph_mode), .ep_nonzero_en(ep_nonzero_en), .sof_pulse(sof_pulse),
  .wakeup(wakeup));
`default_nettype wire
